// file: tccad_pkg.sv
// Shared constants and types for the Type-C CC attach detect block
package tccad_pkg;

	// Per-pin termination class decoded from comparators
	typedef enum logic [1:0] {
		TERM_OPEN,
		TERM_RD,
		TERM_RA
	} tccad_term_t;

	// Role configuration
	typedef enum logic [1:0] {
		ROLE_SOURCE,
		ROLE_SINK,
		ROLE_DUAL
	} tccad_role_t;

	// Advertised current level
	localparam logic [1:0] ADV_DEFAULT = 2'h0;
	localparam logic [1:0] ADV_1P5     = 2'h1;
	localparam logic [1:0] ADV_3P0     = 2'h2;

	// Connection report codes
	localparam logic [2:0] CONN_NONE     = 3'h0;
	localparam logic [2:0] CONN_SINK     = 3'h1;
	localparam logic [2:0] CONN_CABLE    = 3'h2;
	localparam logic [2:0] CONN_CABLE_SK = 3'h3;
	localparam logic [2:0] CONN_DEBUG    = 3'h4;
	localparam logic [2:0] CONN_AUDIO    = 3'h5;
	localparam logic [2:0] CONN_SOURCE   = 3'h6;

	// Dual-role toggle half period
	localparam int          TOGGLE_US     = 35;
	localparam int          CLK_MHZ       = 100;
	localparam int          TOGGLE_CYCLES = TOGGLE_US * CLK_MHZ;
	localparam logic [11:0] TOGGLE_LAST   = 12'(TOGGLE_CYCLES - 1);

	// Strap decode: ADC codes at or above this start in wait-for-external mode
	localparam logic [7:0] STRAP_WAIT_EXT_MIN = 8'hC0;
	localparam logic [7:0] STRAP_SINK_MIN     = 8'h40;

	// Reset values
	localparam logic [2:0] CONN_RST = 3'h0;

endpackage

// file: tccad_port.sv
// Per-port Type-C CC attach detection, role handling, swap and dead-battery logic
`timescale 1ns/1ps
// Overview of operation
// - Source with both pins open watches both, power off.
// - Source sees Rd on CC1: sink attached, VBUS on, watch CC1.
// - Source sees Rd on CC2: sink attached, VBUS on, watch CC2.
// - Ra on CC1 only: cable, watch CC2 attach, CC1 removal, power off.
// - Ra on CC2 only: cable, watch CC1 attach, CC2 removal, power off.
// - Ra CC1 and Rd CC2: VBUS on, VCONN on CC1, watch CC2.
// - Rd CC1 and Ra CC2: VBUS on, VCONN on CC2, watch CC1.
// - Rd on both is debug accessory, Ra on both audio; either detaches.
// - Source drives pull-up current on each pin and classifies voltage.
// - Advertised current selectable default, 1.5 A, 3 A; picks thresholds.
// - Connected: watched pin above sink detect threshold means detach.
// - Pin below cable detect threshold means Ra present.
// - Sink presents trimmed pull-down on both pins.
// - Sink attaches only when VBUS is present.
// - Sink derives partner current level from pull-up strength.
// - Dual role alternates pull-down and pull-up.
// - Sink with swap enabled flags swap below threshold, becomes source.
// - Source requests swap via swap pull-down as it becomes sink.
// - Dead battery presents sink pull-down without firmware action.
// - Dead battery uses untrimmed pull-down; firmware may switch it off.
// - Strap ADC value at power-up picks dead-battery start-up behaviour.
// - Wait-for-external config: port one and two use fixed path pins.
module tccad_port
	import tccad_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Configuration
	input  wire logic [1:0]  role_cfg,
	input  wire logic [1:0]  adv_level,
	input  wire logic        swap_enable,
	input  wire logic        swap_request,
	input  wire logic        powered_up,
	input  wire logic        deadbatt_release,
	input  wire logic        strap_valid,
	input  wire logic [7:0]  strap_adc_input,
	input  wire logic        port_second,
	// Comparator inputs per pin: above sink detect, below cable detect, below swap
	input  wire logic [1:0]  above_sink_detect,
	input  wire logic [1:0]  below_cable_detect,
	input  wire logic [1:0]  below_swap_detect,
	input  wire logic [1:0]  sink_rp_level,
	input  wire logic        vbus_present,
	// Pin controls
	output logic [1:0]       source_pullup_current,
	output logic [1:0]       pullup_level,
	output logic [1:0]       trimmed_sink_pulldown,
	output logic [1:0]       untrimmed_deadbatt_pulldown,
	output logic [1:0]       swap_signal_pulldown,
	output logic [1:0]       cc_watch,
	output logic             vbus_source_en,
	output logic             vbus_sink_en,
	output logic [1:0]       vconn_en,
	// Status
	output logic [2:0]       conn_state,
	output logic [1:0]       partner_level,
	output logic             swap_detected,
	output logic             wait_external_supply_config,
	output logic             ext_path_ctrl_first,
	output logic             ext_path_ctrl_second
);

	typedef enum {
		ST_UNATTACHED,
		ST_ATTACHED_SRC,
		ST_CABLE_ONLY,
		ST_ACCESSORY,
		ST_ATTACHED_SNK
	} tccad_state_t;

	tccad_state_t state_reg;
	tccad_state_t state_next;
	tccad_term_t  term1;
	tccad_term_t  term2;
	logic         src_phase_reg;
	logic [11:0]  toggle_cnt_reg;
	logic         sourcing_reg;
	logic         deadbatt_reg;
	logic         strap_done_reg;
	logic         wait_ext_reg;
	logic [2:0]   conn_reg;
	logic [2:0]   conn_next;
	logic [1:0]   watch_reg;
	logic [1:0]   watch_next;
	logic [1:0]   vconn_reg;
	logic [1:0]   vconn_next;
	logic         vbus_src_reg;
	logic         vbus_src_next;
	logic [1:0]   plevel_reg;
	logic         swap_det_reg;
	logic         swap_sent_reg;

	// Termination class from comparators
	function automatic tccad_term_t classify(input logic above, input logic below);
		if (below)
			return TERM_RA;
		else if (!above)
			return TERM_RD;
		else
			return TERM_OPEN;
	endfunction

	assign term1 = classify(above_sink_detect[0], below_cable_detect[0]);
	assign term2 = classify(above_sink_detect[1], below_cable_detect[1]);

	// Role phase: fixed by config, or toggled for dual role
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			toggle_cnt_reg <= 12'h000;
			src_phase_reg  <= 1'b0;
		end else if (role_cfg == ROLE_DUAL && state_reg == ST_UNATTACHED) begin
			if (toggle_cnt_reg == TOGGLE_LAST) begin
				toggle_cnt_reg <= 12'h000;
				src_phase_reg  <= ~src_phase_reg;
			end else begin
				toggle_cnt_reg <= toggle_cnt_reg + 12'h001;
			end
		end else begin
			toggle_cnt_reg <= 12'h000;
		end
	end

	// Current role; swap events reverse it
	always_ff @(posedge mclk) begin
		if (sys_rst)
			sourcing_reg <= 1'b0;
		else if (state_reg == ST_ATTACHED_SNK && swap_enable && (below_swap_detect & watch_reg) != 2'h0)
			sourcing_reg <= 1'b1;
		else if (state_reg == ST_ATTACHED_SRC && swap_enable && swap_request)
			sourcing_reg <= 1'b0;
		else if (state_reg == ST_UNATTACHED)
			sourcing_reg <= (role_cfg == ROLE_SOURCE) || (role_cfg == ROLE_DUAL && src_phase_reg);
	end

	// Swap flags
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			swap_det_reg  <= 1'b0;
			swap_sent_reg <= 1'b0;
		end else begin
			swap_det_reg  <= state_reg == ST_ATTACHED_SNK && swap_enable
				&& (below_swap_detect & watch_reg) != 2'h0;
			swap_sent_reg <= state_reg == ST_ATTACHED_SRC && swap_enable && swap_request;
		end
	end

	// Attach state machine
	always_comb begin
		state_next    = state_reg;
		conn_next     = conn_reg;
		watch_next    = watch_reg;
		vconn_next    = vconn_reg;
		vbus_src_next = vbus_src_reg;
		unique case (state_reg)
			ST_UNATTACHED: begin
				conn_next     = CONN_NONE;
				watch_next    = 2'h3;
				vconn_next    = 2'h0;
				vbus_src_next = 1'b0;
				if (sourcing_reg) begin
					if (term1 == TERM_RD && term2 == TERM_OPEN) begin
						state_next = ST_ATTACHED_SRC; conn_next = CONN_SINK; watch_next = 2'h1;
						vbus_src_next = 1'b1;
					end else if (term1 == TERM_OPEN && term2 == TERM_RD) begin
						state_next = ST_ATTACHED_SRC; conn_next = CONN_SINK; watch_next = 2'h2;
						vbus_src_next = 1'b1;
					end else if (term1 == TERM_RA && term2 == TERM_RD) begin
						state_next = ST_ATTACHED_SRC; conn_next = CONN_CABLE_SK; watch_next = 2'h2;
						vbus_src_next = 1'b1; vconn_next = 2'h1;
					end else if (term1 == TERM_RD && term2 == TERM_RA) begin
						state_next = ST_ATTACHED_SRC; conn_next = CONN_CABLE_SK; watch_next = 2'h1;
						vbus_src_next = 1'b1; vconn_next = 2'h2;
					end else if (term1 == TERM_RA && term2 == TERM_OPEN) begin
						state_next = ST_CABLE_ONLY; conn_next = CONN_CABLE; watch_next = 2'h3;
					end else if (term1 == TERM_OPEN && term2 == TERM_RA) begin
						state_next = ST_CABLE_ONLY; conn_next = CONN_CABLE; watch_next = 2'h3;
					end else if (term1 == term2 && term1 != TERM_OPEN) begin
						state_next = ST_ACCESSORY; watch_next = 2'h3;
						conn_next  = (term1 == TERM_RD) ? CONN_DEBUG : CONN_AUDIO;
					end
				end else if (vbus_present) begin
					state_next = ST_ATTACHED_SNK; conn_next = CONN_SOURCE;
					watch_next = above_sink_detect[0] ? 2'h1 : 2'h2;
				end
			end
			ST_CABLE_ONLY: begin
				// Cable pin watched for removal, other pin for a sink
				if (term1 == TERM_OPEN && term2 == TERM_OPEN) begin
					state_next = ST_UNATTACHED;
				end else if (term1 == TERM_RA && term2 == TERM_RD) begin
					state_next = ST_ATTACHED_SRC; conn_next = CONN_CABLE_SK; watch_next = 2'h2;
					vbus_src_next = 1'b1; vconn_next = 2'h1;
				end else if (term1 == TERM_RD && term2 == TERM_RA) begin
					state_next = ST_ATTACHED_SRC; conn_next = CONN_CABLE_SK; watch_next = 2'h1;
					vbus_src_next = 1'b1; vconn_next = 2'h2;
				end
			end
			ST_ATTACHED_SRC: begin
				if ((above_sink_detect & watch_reg) == watch_reg) begin
					state_next = ST_UNATTACHED;
				end else if (swap_enable && swap_request) begin
					state_next = ST_ATTACHED_SNK; conn_next = CONN_SOURCE;
					vbus_src_next = 1'b0; vconn_next = 2'h0;
				end
			end
			ST_ACCESSORY: begin
				if (above_sink_detect != 2'h0)
					state_next = ST_UNATTACHED;
			end
			ST_ATTACHED_SNK: begin
				if (swap_enable && (below_swap_detect & watch_reg) != 2'h0) begin
					state_next = ST_ATTACHED_SRC; conn_next = CONN_SINK; vbus_src_next = 1'b1;
				end else if (!vbus_present) begin
					state_next = ST_UNATTACHED;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg    <= ST_UNATTACHED;
			conn_reg     <= CONN_RST;
			watch_reg    <= 2'h3;
			vconn_reg    <= 2'h0;
			vbus_src_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			conn_reg     <= conn_next;
			watch_reg    <= watch_next;
			vconn_reg    <= vconn_next;
			vbus_src_reg <= vbus_src_next;
		end
	end

	// Partner current level while sinking
	always_ff @(posedge mclk) begin
		if (sys_rst)
			plevel_reg <= ADV_DEFAULT;
		else if (state_reg == ST_ATTACHED_SNK)
			plevel_reg <= sink_rp_level;
		else
			plevel_reg <= ADV_DEFAULT;
	end

	// Dead battery: set by strap at power-up, cleared by firmware once powered
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			deadbatt_reg   <= 1'b1;
			strap_done_reg <= 1'b0;
			wait_ext_reg   <= 1'b0;
		end else begin
			if (strap_valid && !strap_done_reg) begin
				strap_done_reg <= 1'b1;
				wait_ext_reg   <= strap_adc_input >= STRAP_WAIT_EXT_MIN;
				deadbatt_reg   <= strap_adc_input >= STRAP_SINK_MIN;
			end else if (powered_up && deadbatt_release) begin
				deadbatt_reg <= 1'b0;
			end
		end
	end

	// Pin drive
	always_comb begin
		source_pullup_current       = 2'h0;
		trimmed_sink_pulldown       = 2'h0;
		untrimmed_deadbatt_pulldown = 2'h0;
		if (deadbatt_reg && !powered_up) begin
			untrimmed_deadbatt_pulldown = 2'h3;
		end else if (sourcing_reg) begin
			source_pullup_current = 2'h3;
		end else begin
			trimmed_sink_pulldown = 2'h3;
			untrimmed_deadbatt_pulldown = deadbatt_reg ? 2'h3 : 2'h0;
		end
	end

	assign pullup_level         = adv_level;
	assign swap_signal_pulldown = swap_sent_reg ? watch_reg : 2'h0;
	assign cc_watch             = watch_reg;
	assign vbus_source_en       = vbus_src_reg;
	assign vbus_sink_en         = state_reg == ST_ATTACHED_SNK;
	assign vconn_en             = vconn_reg;
	assign conn_state           = conn_reg;
	assign partner_level        = plevel_reg;
	assign swap_detected        = swap_det_reg;
	assign wait_external_supply_config = wait_ext_reg;
	assign ext_path_ctrl_first  = wait_ext_reg && !port_second && (vbus_src_reg || vbus_sink_en);
	assign ext_path_ctrl_second = wait_ext_reg && port_second && (vbus_src_reg || vbus_sink_en);

	// Checks
	property p_idle_unpowered;
		@(posedge mclk) disable iff (sys_rst) state_reg == ST_UNATTACHED |=> !vbus_src_reg || state_reg != ST_UNATTACHED;
	endproperty
	a_idle_unpowered: assert property (p_idle_unpowered) else $error("VBUS on while unattached");
	property p_rd_cc1;
		@(posedge mclk) disable iff (sys_rst)
			state_reg == ST_UNATTACHED && sourcing_reg && term1 == TERM_RD && term2 == TERM_OPEN
			|=> vbus_src_reg && watch_reg == 2'h1 && vconn_reg == 2'h0 && conn_reg == CONN_SINK;
	endproperty
	a_rd_cc1: assert property (p_rd_cc1) else $error("CC1 sink attach wrong");
	property p_rd_cc2;
		@(posedge mclk) disable iff (sys_rst)
			state_reg == ST_UNATTACHED && sourcing_reg && term1 == TERM_OPEN && term2 == TERM_RD
			|=> vbus_src_reg && watch_reg == 2'h2 && vconn_reg == 2'h0;
	endproperty
	a_rd_cc2: assert property (p_rd_cc2) else $error("CC2 sink attach wrong");
	property p_cable_off;
		@(posedge mclk) disable iff (sys_rst) state_reg == ST_CABLE_ONLY |-> !vbus_src_reg && vconn_reg == 2'h0;
	endproperty
	a_cable_off: assert property (p_cable_off) else $error("Power on with cable only");
	property p_vconn_cc1;
		@(posedge mclk) disable iff (sys_rst)
			state_reg == ST_UNATTACHED && sourcing_reg && term1 == TERM_RA && term2 == TERM_RD
			|=> vconn_reg == 2'h1 && watch_reg == 2'h2;
	endproperty
	a_vconn_cc1: assert property (p_vconn_cc1) else $error("VCONN CC1 wrong");
	property p_sink_vbus;
		@(posedge mclk) disable iff (sys_rst)
			$rose(state_reg == ST_ATTACHED_SNK) && $past(state_reg) == ST_UNATTACHED |-> $past(vbus_present);
	endproperty
	a_sink_vbus: assert property (p_sink_vbus) else $error("Sink attach without VBUS");
	property p_detach;
		@(posedge mclk) disable iff (sys_rst)
			state_reg == ST_ATTACHED_SRC && (above_sink_detect & watch_reg) == watch_reg
			|=> state_reg == ST_UNATTACHED ##1 !vbus_src_reg;
	endproperty
	a_detach: assert property (p_detach) else $error("Detach missed");
	property p_deadbatt;
		@(posedge mclk) disable iff (sys_rst) deadbatt_reg && !powered_up |-> untrimmed_deadbatt_pulldown == 2'h3;
	endproperty
	a_deadbatt: assert property (p_deadbatt) else $error("Dead battery pull-down missing");
	c_sink_attach: cover property (@(posedge mclk) disable iff (sys_rst) conn_reg == CONN_SINK);
	c_cable_sink: cover property (@(posedge mclk) disable iff (sys_rst) conn_reg == CONN_CABLE_SK);
	c_swap: cover property (@(posedge mclk) disable iff (sys_rst) swap_det_reg);
endmodule

// file: tccad_partner.sv
// Port partner model: turns CC terminations and supply into comparator levels
`timescale 1ns/1ps
module tccad_partner
	import tccad_pkg::*;
(
	// Partner terminations and supply
	input  wire tccad_term_t term1,
	input  wire tccad_term_t term2,
	input  wire logic        vbus_on,
	input  wire logic [1:0]  rp_code,
	input  wire logic        swap_drop,
	input  wire logic        dev_pullup,
	// Comparator view at the block
	output logic [1:0]       above_sink_detect,
	output logic [1:0]       below_cable_detect,
	output logic [1:0]       below_swap_detect,
	output logic [1:0]       sink_rp_level,
	output logic             vbus_present
);
	// Device pulling up: open pin floats high, Ra below cable level, Rd between
	// Device sinking: only a pin with a partner pull-up rises above the detect level
	always_comb begin
		above_sink_detect  = dev_pullup ? {term2 == TERM_OPEN, term1 == TERM_OPEN}
			: {term2 != TERM_OPEN, term1 != TERM_OPEN};
		below_cable_detect = {term2 == TERM_RA, term1 == TERM_RA};
		below_swap_detect  = {2{swap_drop}};
		sink_rp_level      = rp_code;
		vbus_present       = vbus_on;
	end
endmodule

// file: tb_top.sv
// Self-checking bench for the per-port CC attach detect logic
`timescale 1ns/1ps
module tb_top
	import tccad_pkg::*;
;
	logic mclk, sys_rst, swap_enable, swap_request, powered_up, deadbatt_release, strap_valid, vbus_on, swap_drop;
	logic [1:0] role_cfg, adv_level, rp_code, above_sink_detect, below_cable_detect, below_swap_detect, sink_rp_level;
	logic [1:0] source_pullup_current, pullup_level, trimmed_sink_pulldown, untrimmed_deadbatt_pulldown;
	logic [1:0] swap_signal_pulldown, cc_watch, vconn_en, partner_level, prev;
	logic [2:0] conn_state;
	logic [7:0] strap;
	logic [15:0] e;
	logic vbus_present, vbus_source_en, vbus_sink_en, swap_detected, wait_external_supply_config;
	logic ext_path_ctrl_first, ext_path_ctrl_second, hit, port_second;
	tccad_term_t term1, term2;
	int errors, check_count, n;

	tccad_partner partner (.term1(term1), .term2(term2), .vbus_on(vbus_on), .rp_code(rp_code),
		.swap_drop(swap_drop), .dev_pullup(source_pullup_current != 2'h0),
		.above_sink_detect(above_sink_detect), .below_cable_detect(below_cable_detect),
		.below_swap_detect(below_swap_detect), .sink_rp_level(sink_rp_level), .vbus_present(vbus_present));

	tccad_port uut (.mclk(mclk), .sys_rst(sys_rst), .role_cfg(role_cfg), .adv_level(adv_level),
		.swap_enable(swap_enable), .swap_request(swap_request), .powered_up(powered_up),
		.deadbatt_release(deadbatt_release), .strap_valid(strap_valid), .strap_adc_input(strap),
		.port_second(port_second), .above_sink_detect(above_sink_detect), .below_cable_detect(below_cable_detect),
		.below_swap_detect(below_swap_detect), .sink_rp_level(sink_rp_level), .vbus_present(vbus_present),
		.source_pullup_current(source_pullup_current), .pullup_level(pullup_level),
		.trimmed_sink_pulldown(trimmed_sink_pulldown), .untrimmed_deadbatt_pulldown(untrimmed_deadbatt_pulldown),
		.swap_signal_pulldown(swap_signal_pulldown), .cc_watch(cc_watch), .vbus_source_en(vbus_source_en),
		.vbus_sink_en(vbus_sink_en), .vconn_en(vconn_en), .conn_state(conn_state), .partner_level(partner_level),
		.swap_detected(swap_detected), .wait_external_supply_config(wait_external_supply_config),
		.ext_path_ctrl_first(ext_path_ctrl_first), .ext_path_ctrl_second(ext_path_ctrl_second));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ends the run when a bounded wait ran out
	task automatic wait_hit(input string what);
		chk(what, 8'h01, {7'h00, hit});
		if (hit !== 1'b1) tally_and_finish();
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask

	task automatic pat(input tccad_term_t a, input tccad_term_t b);
		@(negedge mclk);
		term1 = a;
		term2 = b;
		@(negedge mclk);
	endtask

	task automatic do_reset(input logic [1:0] role, input logic [7:0] s);
		@(negedge mclk);
		sys_rst = 1'b1;
		role_cfg = role;
		strap = s;
		powered_up = 1'b0;
		deadbatt_release = 1'b0;
		cyc(5);
		sys_rst = 1'b0;
		cyc(1);
	endtask

	// Mask in upper byte; state {conn, vbus, vconn, watch} in lower byte
	function automatic logic [15:0] src_exp(input tccad_term_t a, input tccad_term_t b);
		case ({a, b})
			{TERM_RD, TERM_OPEN}: return {8'hFF, CONN_SINK, 1'b1, 2'b00, 2'b01};
			{TERM_OPEN, TERM_RD}: return {8'hFF, CONN_SINK, 1'b1, 2'b00, 2'b10};
			{TERM_RA, TERM_OPEN}: return {8'hFC, CONN_CABLE, 1'b0, 2'b00, 2'b00};
			{TERM_OPEN, TERM_RA}: return {8'hFC, CONN_CABLE, 1'b0, 2'b00, 2'b00};
			{TERM_RA, TERM_RD}: return {8'hFF, CONN_CABLE_SK, 1'b1, 2'b01, 2'b10};
			{TERM_RD, TERM_RA}: return {8'hFF, CONN_CABLE_SK, 1'b1, 2'b10, 2'b01};
			{TERM_RD, TERM_RD}: return {8'hE3, CONN_DEBUG, 1'b0, 2'b00, 2'b11};
			{TERM_RA, TERM_RA}: return {8'hE3, CONN_AUDIO, 1'b0, 2'b00, 2'b11};
			default: return {8'hFF, CONN_NONE, 1'b0, 2'b00, 2'b11};
		endcase
	endfunction

	task automatic src_case(input tccad_term_t a, input tccad_term_t b);
		pat(a, b);
		e = src_exp(a, b);
		chk("src_state", e[7:0] & e[15:8], {conn_state, vbus_source_en, vconn_en, cc_watch} & e[15:8]);
		pat(TERM_OPEN, TERM_OPEN);
		// Outputs clear one edge after the state falls back to unattached
		cyc(1);
		chk("idle_state", {CONN_NONE, 5'h03}, {conn_state, vbus_source_en, vconn_en, cc_watch});
	endtask

	task automatic wait_until_swap(input logic sink_side);
		hit = 1'b0;
		for (n = 0; n < 8 && !hit; n++) begin
			@(negedge mclk);
			hit = sink_side ? swap_detected === 1'b1 : swap_signal_pulldown === 2'b01;
		end
	endtask

	initial begin
		{errors, check_count} = '0;
		{sys_rst, swap_enable, swap_request, powered_up, deadbatt_release, vbus_on, swap_drop, port_second} = '0;
		{role_cfg, adv_level, rp_code, strap} = '0;
		strap_valid = 1'b1;
		term1 = TERM_OPEN;
		term2 = TERM_OPEN;
		void'($urandom(32'h6561A3F1));
		do_reset(2'h0, 8'hC0);
		chk("wait_ext", 8'h01, {7'h00, wait_external_supply_config});
		chk("path_second", 8'h00, {7'h00, ext_path_ctrl_second});
		chk("db_pulldown", 8'h03, {6'h00, untrimmed_deadbatt_pulldown});
		// Supply present, so the source pull-up current is driven
		powered_up = 1'b1;
		for (int i = 0; i < 3; i++) begin
			adv_level = 2'(i);
			cyc(1);
			chk("pullup_level", {6'h00, adv_level}, {6'h00, pullup_level});
			chk("pullup_current", 8'h03, {6'h00, source_pullup_current});
		end
		for (int i = 0; i < 9; i++) src_case(tccad_term_t'(i / 3), tccad_term_t'(i % 3));
		repeat (20) begin
			adv_level = 2'($urandom_range(2));
			src_case(tccad_term_t'($urandom_range(2)), tccad_term_t'($urandom_range(2)));
		end
		// CC1 carries VCONN, so losing it must not count as detach
		pat(TERM_RA, TERM_RD);
		pat(TERM_OPEN, TERM_RD);
		chk("cc1_ignored", {4'h0, CONN_CABLE_SK, 1'b1}, {4'h0, conn_state, vbus_source_en});
		chk("path_first", 8'h01, {7'h00, ext_path_ctrl_first});
		port_second = 1'b1;
		cyc(1);
		chk("path_second_on", 8'h01, {7'h00, ext_path_ctrl_second});
		chk("path_first_off", 8'h00, {7'h00, ext_path_ctrl_first});
		port_second = 1'b0;
		pat(TERM_OPEN, TERM_OPEN);
		cyc(1);
		chk("cc2_detach", {4'h0, CONN_NONE, 1'b0}, {4'h0, conn_state, vbus_source_en});
		swap_enable = 1'b1;
		pat(TERM_RD, TERM_OPEN);
		swap_request = 1'b1;
		wait_until_swap(1'b0);
		wait_hit("swap_pulldown");
		// Partner takes over the supply after the swap signal
		vbus_on = 1'b1;
		cyc(8);
		chk("swap_stops_src", 8'h00, {7'h00, vbus_source_en});
		chk("swap_now_sink", 8'h01, {7'h00, vbus_sink_en});
		swap_request = 1'b0;
		swap_enable = 1'b0;
		vbus_on = 1'b0;
		$display("test %s done", "source");
		do_reset(2'h1, 8'hBF);
		chk("wait_ext", 8'h00, {7'h00, wait_external_supply_config});
		chk("db_pulldown", 8'h03, {6'h00, untrimmed_deadbatt_pulldown});
		powered_up = 1'b1;
		deadbatt_release = 1'b1;
		cyc(2);
		chk("db_released", 8'h00, {6'h00, untrimmed_deadbatt_pulldown});
		chk("trimmed_on", 8'h03, {6'h00, trimmed_sink_pulldown});
		rp_code = 2'($urandom_range(2));
		pat(TERM_RD, TERM_OPEN);
		cyc(3);
		chk("no_vbus", {5'h00, CONN_NONE}, {5'h00, conn_state});
		vbus_on = 1'b1;
		hit = 1'b0;
		for (n = 0; n < 8 && !hit; n++) begin
			@(negedge mclk);
			hit = conn_state === CONN_SOURCE;
		end
		wait_hit("sink_attach");
		chk("sink_vbus_en", 8'h01, {7'h00, vbus_sink_en});
		// Partner level is registered one edge after the attach
		cyc(1);
		chk("partner_level", {6'h00, rp_code}, {6'h00, partner_level});
		swap_enable = 1'b1;
		swap_drop = 1'b1;
		wait_until_swap(1'b1);
		wait_hit("swap_flag");
		cyc(8);
		chk("now_source", 8'h03, {6'h00, source_pullup_current});
		{swap_drop, swap_enable, vbus_on} = '0;
		pat(TERM_OPEN, TERM_OPEN);
		$display("test %s done", "sink");
		do_reset(2'h2, 8'h10);
		powered_up = 1'b1;
		deadbatt_release = 1'b1;
		cyc(2);
		prev = source_pullup_current;
		hit = 1'b0;
		for (n = 0; n < 4000 && !hit; n++) begin
			@(negedge mclk);
			hit = source_pullup_current !== prev;
		end
		wait_hit("toggle");
		chk("toggle_pair", {6'h00, ~source_pullup_current}, {6'h00, trimmed_sink_pulldown});
		$display("test %s done", "dual");
		tally_and_finish();
	end

	initial begin
		#900000;
		errors++;
		$display("wrong value run_time expected done seen hung");
		tally_and_finish();
	end
endmodule
